// file: quad_uart_serial_modem_pins.v
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`include "quad_uart_pins_consts.vh"

module quad_uart_serial_modem_pins #(
  parameter NUM_CH = 4,
  parameter TICK_DIV = 8
) (
  input wire mclk,
  input wire reset,
  input wire [6:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output wire [NUM_CH-1:0] tx_out,
  output wire [NUM_CH-1:0] infrared_tx_out,
  output wire [NUM_CH-1:0] rts_n,
  output wire [NUM_CH-1:0] dtr_n,
  input wire [NUM_CH-1:0] rx_in,
  input wire [NUM_CH-1:0] cts_n,
  input wire [NUM_CH-1:0] dsr_n,
  input wire [NUM_CH-1:0] ri_n,
  input wire [NUM_CH-1:0] cd_n,
  output reg irq
);

  // Address decode shared by every channel
  function hit;
    input [6:0] addr;
    input [1:0] ch;
    input [2:0] idx;
    begin
      hit = (addr[6:5] == ch) && (addr[4:2] == idx);
    end
  endfunction

  reg [7:0] div_cnt; // Mclk divider for 16x tick
  reg tick; // One-cycle 16x enable
  wire wr_acc; // Write taken this edge
  wire rd_acc; // Read taken this edge
  wire [NUM_CH*8-1:0] ch_rd; // Per-channel read data, zero if not addressed
  wire [NUM_CH-1:0] ch_irq; // Per-channel enabled status
  reg [7:0] rd_any; // Merged read data
  integer k;

  assign wr_acc = avs_write & ~avs_waitrequest;
  assign rd_acc = avs_read & ~avs_waitrequest;

  // 16x tick generator; one clock, slower rates as enables
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end else if (div_cnt == TICK_DIV[7:0] - 8'h01) begin
      div_cnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      tick <= 1'b0;
    end
  end

  // Merge channel read data
  always @* begin
    rd_any = 8'h00;
    for (k = 0; k < NUM_CH; k = k + 1) begin
      rd_any = rd_any | ch_rd[k*8 +: 8];
    end
  end

  // Avalon slave: waitrequest drops one cycle after a request appears
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      irq <= |ch_irq; // Level, high while an enabled status bit stands
      if (!avs_waitrequest) begin
        avs_waitrequest <= 1'b1; // Back to waiting after the accept edge
      end else if (avs_read | avs_write) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= {24'h000000, rd_any};
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i = i + 1) begin : chan
      reg [7:0] modem_control_reg; // modem_control_reg
      reg [7:0] feature_control_reg; // feature_control_reg
      reg [7:0] enhanced_feature_reg; // enhanced_feature_reg
      reg [7:0] interrupt_enable_reg; // interrupt_enable_reg, also the interrupt mask
      reg [7:0] ist; // Sticky interrupt status
      reg [4:0] s1; // Pin sync stage 1, read only by s2
      reg [4:0] s2;
      reg [4:0] s3;
      reg [4:0] stab; // Filtered pins {cd,ri,dsr,cts,rx}, active-low as on the pins
      reg [3:0] ir_hold; // Stretches a received IR pulse to a bit
      reg rx_busy;
      reg [3:0] rx_tick;
      reg [3:0] rx_bit;
      reg [7:0] rx_sh;
      reg [7:0] rx_data;
      reg rx_ready; // Unread byte present
      reg rx_done; // One-cycle event
      reg tx_busy;
      reg tx_pend; // Byte waiting for the shifter
      reg [7:0] tx_hold;
      reg [9:0] tx_sh;
      reg [3:0] tx_tick;
      reg [3:0] tx_bit;
      reg tx_done; // One-cycle event
      reg txo; // Muxed transmit pin
      reg irtx; // Dedicated IR pin
      reg dtr_q; // Handshake pin flop, updated with the control write
      localparam [1:0] CH_ID = i; // Channel number at address width
      reg rts_q;
      reg [5:0] hyst_cnt; // Ticks left before auto RTS reasserts
      reg [7:0] rd;
      wire [4:0] pins;
      wire rx_lvl;
      wire rx_line;
      wire ir_enc;
      wire nrz;
      wire cts_block;
      wire [7:0] ev;
      wire [7:0] clr;

      assign pins = {cd_n[i], ri_n[i], dsr_n[i], cts_n[i], rx_in[i]};
      // Polarity flip before the decoder allows high-idle transceivers
      assign rx_lvl = stab[0] ^ feature_control_reg[`FEATURE_CONTROL_REG_RX_INV];
      // Decoded IR: a high pulse or its stretch is a zero bit
      assign rx_line = modem_control_reg[`MCR_IR_SEL] ? ~(rx_lvl | (ir_hold != 4'h0)) : stab[0];
      // Encoder: 3/16 pulse in mid bit for zero bits only, low otherwise
      assign ir_enc = tx_busy & ~tx_sh[0] & (tx_tick >= `IR_PULSE_FIRST) &
                      (tx_tick <= `IR_PULSE_LAST);
      assign nrz = tx_busy ? tx_sh[0] : 1'b1;
      // Auto CTS: a high clear-to-send holds the next character back
      assign cts_block = enhanced_feature_reg[`EFR_AUTO_CTS] & stab[1];
      assign ev = {6'h00, tx_done, rx_done};
      assign clr = (wr_acc && hit(avs_address, CH_ID, `REG_INT_CLEAR)) ? avs_writedata[7:0] : 8'h00;

      assign tx_out[i] = txo;
      assign infrared_tx_out[i] = irtx;
      assign rts_n[i] = rts_q;
      assign dtr_n[i] = dtr_q;
      assign ch_irq[i] = |(ist & interrupt_enable_reg);
      assign ch_rd[i*8 +: 8] = (avs_address[6:5] == CH_ID) ? rd : 8'h00;

      // Software registers
      always @(posedge mclk or posedge reset) begin
        if (reset) begin
          modem_control_reg <= `RST_CTRL;
          feature_control_reg <= `RST_CTRL;
          enhanced_feature_reg <= `RST_CTRL;
          interrupt_enable_reg <= `RST_CTRL;
          dtr_q <= 1'b1;
        end else if (wr_acc) begin
          if (hit(avs_address, CH_ID, `REG_MODEM_CTRL)) begin
            modem_control_reg <= avs_writedata[7:0];
            dtr_q <= ~avs_writedata[`MCR_DTR];
          end
          if (hit(avs_address, CH_ID, `REG_FEATURE_CTRL)) feature_control_reg <= avs_writedata[7:0];
          if (hit(avs_address, CH_ID, `REG_ENH_FEATURE)) enhanced_feature_reg <= avs_writedata[7:0];
          if (hit(avs_address, CH_ID, `REG_INT_ENABLE)) interrupt_enable_reg <= avs_writedata[7:0];
        end
      end

      // Three-stage pin sync; a bit moves once stages 2 and 3 agree
      always @(posedge mclk or posedge reset) begin
        if (reset) begin
          s1 <= `RST_PINS;
          s2 <= `RST_PINS;
          s3 <= `RST_PINS;
          stab <= `RST_PINS;
        end else begin
          s1 <= pins;
          s2 <= s1;
          s3 <= s2;
          stab <= (s2 & s3) | (stab & (s2 ^ s3));
        end
      end

      // Sticky status: events set, writes to the clear register clear, set wins
      always @(posedge mclk or posedge reset) begin
        if (reset) begin
          ist <= 8'h00;
        end else begin
          ist <= (ist & ~clr) | ev;
          ist[`IST_MODEM] <= (ist[`IST_MODEM] & ~clr[`IST_MODEM]) |
                             (|((s2[4:2] ~^ s3[4:2]) & (s3[4:2] ^ stab[4:2])));
          ist[`IST_CTS] <= (ist[`IST_CTS] & ~clr[`IST_CTS]) |
                           ((s2[1] ~^ s3[1]) & (s3[1] ^ stab[1]));
        end
      end

      // IR pulse stretcher, counted in ticks
      always @(posedge mclk or posedge reset) begin
        if (reset) begin
          ir_hold <= 4'h0;
        end else if (rx_lvl && modem_control_reg[`MCR_IR_SEL]) begin
          ir_hold <= `IR_HOLD; // Pulse seen; no stale stretch on a mode switch
        end else if (tick && ir_hold != 4'h0) begin
          ir_hold <= ir_hold - 4'h1;
        end
      end

      // Receiver: start on low, sample mid bit, 8 data, 1 stop
      // In standard mode the far end must idle the line high
      always @(posedge mclk or posedge reset) begin
        if (reset) begin
          rx_busy <= 1'b0;
          rx_tick <= 4'h0;
          rx_bit <= 4'h0;
          rx_sh <= 8'h00;
          rx_data <= 8'h00;
          rx_ready <= 1'b0;
          rx_done <= 1'b0;
        end else begin
          rx_done <= 1'b0;
          // Reading the data register frees the byte; a new byte wins
          if (rd_acc && hit(avs_address, CH_ID, `REG_DATA)) rx_ready <= 1'b0;
          if (tick) begin
            if (!rx_busy) begin
              if (!rx_line) begin
                rx_busy <= 1'b1;
                rx_tick <= 4'h0;
                rx_bit <= 4'h0;
              end
            end else begin
              rx_tick <= rx_tick + 4'h1;
              if (rx_tick == `TICK_MID) begin
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'h0) begin
                  if (rx_line) rx_busy <= 1'b0; // False start
                end else if (rx_bit == `BIT_STOP) begin
                  rx_busy <= 1'b0;
                  rx_data <= rx_sh;
                  rx_ready <= 1'b1;
                  rx_done <= 1'b1;
                end else begin
                  rx_sh <= {rx_line, rx_sh[7:1]};
                end
              end
            end
          end
        end
      end

      // Transmitter: start, 8 data LSB first, stop; held off by auto CTS
      always @(posedge mclk or posedge reset) begin
        if (reset) begin
          tx_busy <= 1'b0;
          tx_pend <= 1'b0;
          tx_hold <= 8'h00;
          tx_sh <= 10'h3ff;
          tx_tick <= 4'h0;
          tx_bit <= 4'h0;
          tx_done <= 1'b0;
        end else begin
          tx_done <= 1'b0;
          if (wr_acc && hit(avs_address, CH_ID, `REG_DATA)) begin
            tx_hold <= avs_writedata[7:0]; // Overwrites a byte not yet started
            tx_pend <= 1'b1;
          end
          if (tick) begin
            if (!tx_busy) begin
              if (tx_pend && !cts_block && !(wr_acc && hit(avs_address, CH_ID, `REG_DATA))) begin
                tx_busy <= 1'b1;
                tx_pend <= 1'b0;
                tx_sh <= {1'b1, tx_hold, 1'b0};
                tx_tick <= 4'h0;
                tx_bit <= 4'h0;
              end
            end else begin
              tx_tick <= tx_tick + 4'h1;
              if (tx_tick == `TICK_LAST) begin
                tx_sh <= {1'b1, tx_sh[9:1]};
                tx_bit <= tx_bit + 4'h1;
                if (tx_bit == `BIT_STOP) begin
                  tx_busy <= 1'b0;
                  tx_done <= 1'b1;
                end
              end
            end
          end
        end
      end

      // Pin drivers: high in reset (standard), low IR idle
      always @(posedge mclk or posedge reset) begin
        if (reset) begin
          txo <= 1'b1;
          irtx <= 1'b0;
        end else begin
          txo <= modem_control_reg[`MCR_IR_SEL] ? ir_enc : nrz;
          irtx <= ir_enc;
        end
      end

      // RTS: software level, or auto mode once software asserted it
      always @(posedge mclk or posedge reset) begin
        if (reset) begin
          rts_q <= 1'b1;
          hyst_cnt <= 6'h00;
        end else if (enhanced_feature_reg[`EFR_AUTO_RTS] && modem_control_reg[`MCR_RTS]) begin
          if (rx_ready) begin
            rts_q <= 1'b1;
            hyst_cnt <= {feature_control_reg[`FEATURE_CONTROL_REG_HYST_LO+1:`FEATURE_CONTROL_REG_HYST_LO], 4'h0};
          end else if (hyst_cnt != 6'h00) begin
            if (tick) hyst_cnt <= hyst_cnt - 6'h01;
          end else begin
            rts_q <= 1'b0;
          end
        end else begin
          rts_q <= ~modem_control_reg[`MCR_RTS];
          hyst_cnt <= 6'h00;
        end
      end

      // Read mux; pin states shown active-high
      always @* begin
        case (avs_address[4:2])
          `REG_DATA: rd = rx_data;
          `REG_INT_ENABLE: rd = interrupt_enable_reg;
          `REG_FEATURE_CTRL: rd = feature_control_reg;
          `REG_ENH_FEATURE: rd = enhanced_feature_reg;
          `REG_MODEM_CTRL: rd = modem_control_reg;
          `REG_MODEM_STAT: rd = {1'b0, ~rts_q, rx_ready, tx_busy | tx_pend, ~stab[4:1]};
          `REG_INT_STATUS: rd = ist;
          default: rd = 8'h00; // Clear register is write-only
        endcase
      end
    end
  endgenerate

endmodule

// file: quad_uart_pins_consts.vh
// How it works
// - Standard mode: TX pin idles and resets high
// - Infrared select: TX/RX use IR, idle low
// - Dedicated IR output always encoded, rests low
// - IR decoder expects low idle; polarity invertible
// - RTS asserted first, then auto RTS hysteresis
// - CTS is input or auto transmit gate
// - DTR output is handshake or software output
// - DSR input readable as handshake or input
// - CD and RI inputs readable as status
`ifndef QUAD_UART_PINS_CONSTS_VH
`define QUAD_UART_PINS_CONSTS_VH

// Word index of each per-channel register (byte address bits 4:2)
`define REG_DATA 3'h0
`define REG_INT_ENABLE 3'h1
`define REG_FEATURE_CTRL 3'h2
`define REG_ENH_FEATURE 3'h3
`define REG_MODEM_CTRL 3'h4
`define REG_MODEM_STAT 3'h5
`define REG_INT_STATUS 3'h6
`define REG_INT_CLEAR 3'h7

// Field positions
`define MCR_DTR 0
`define MCR_RTS 1
`define MCR_IR_SEL 6
`define FEATURE_CONTROL_REG_HYST_LO 0
`define FEATURE_CONTROL_REG_RX_INV 2
`define EFR_AUTO_RTS 6
`define EFR_AUTO_CTS 7
`define IST_RX_DONE 0
`define IST_TX_DONE 1
`define IST_MODEM 2
`define IST_CTS 7

// Reset values
`define RST_CTRL 8'h00
`define RST_PINS 5'h1f

// Timing in 16x ticks; BIT_STOP counts bits
`define TICK_LAST 4'hf
`define TICK_MID 4'h7
`define IR_PULSE_FIRST 4'h6
`define IR_PULSE_LAST 4'h8
`define IR_HOLD 4'hf
`define BIT_STOP 4'h9

`endif

// file: quad_uart_pins_sva.sv
`timescale 1ns/10ps
`include "quad_uart_pins_consts.vh"
module quad_uart_pins_chk #(
  parameter NUM_CH = 4,
  parameter TICK_DIV = 8
) (
  input wire mclk,
  input wire reset,
  input wire [6:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [NUM_CH-1:0] infrared_tx_out,
  input wire [NUM_CH-1:0] tx_out,
  input wire [NUM_CH-1:0] dtr_n,
  input wire irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Accepted modem control write
  wire acc_mcr = avs_write && !avs_waitrequest && avs_address[4:2] == `REG_MODEM_CTRL;
  // Channel and data bit of the last cycle
  reg [1:0] wch;
  reg wd0;
  // High time of the channel 0 pulse
  reg [7:0] hi_len;
  always @(posedge mclk) begin
    wch <= avs_address[6:5];
    wd0 <= avs_writedata[0];
  end
  // Counter restarts on every low cycle
  always @(posedge mclk or posedge reset) begin
    if (reset) hi_len <= 8'h00;
    else if (infrared_tx_out[0]) hi_len <= hi_len + 8'h01;
    else hi_len <= 8'h00;
  end
  sequence req_new;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_req_answer: assert property (req_new |=> answer)
    else $error("request not answered in one cycle");
  a_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without request");
  a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  a_rdata_hold: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data moved between answers");
  a_dtr_follow: assert property (acc_mcr |=> dtr_n[wch] == !wd0)
    else $error("handshake output does not follow control bit");
  a_dtr_hold: assert property (!acc_mcr |=> $stable(dtr_n))
    else $error("handshake output moved without write");
  a_ir_pulse: assert property ($fell(infrared_tx_out[0]) |-> hi_len == 3 * TICK_DIV)
    else $error("pulse width wrong");
  a_reset_levels: assert property (disable iff (1'b0) reset |-> tx_out == {NUM_CH{1'b1}}
    && infrared_tx_out == {NUM_CH{1'b0}} && dtr_n == {NUM_CH{1'b1}} && !irq)
    else $error("outputs not at reset level");
endmodule
bind quad_uart_serial_modem_pins quad_uart_pins_chk #(.NUM_CH(NUM_CH), .TICK_DIV(TICK_DIV)) chk (
  .mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .infrared_tx_out(infrared_tx_out), .tx_out(tx_out),
  .dtr_n(dtr_n), .irq(irq));

// file: remote_serial_peer.sv
`timescale 1ns/10ps
module remote_serial_peer #(
  parameter TICK_DIV = 1
) (
  input wire mclk,
  input wire [3:0] tx_out,
  output reg [3:0] rx_in
);
  localparam BIT_CYC = 16 * TICK_DIV;
  // Lines start high; a pulse-coded character leaves its line at the inv level
  initial rx_in = 4'hf;
  // One 8N1 character, NRZ or pulse coded, the pulse code optionally inverted
  task send(input integer ch, input [7:0] b, input bit ir, input bit inv);
    reg [9:0] fr;
    integer i, t;
    begin
      fr = {1'b1, b, 1'b0};
      for (i = 0; i < 10; i = i + 1)
        for (t = 0; t < BIT_CYC; t = t + 1) begin
          @(posedge mclk);
          if (ir) rx_in[ch] <= inv ^ (!fr[i] && t / TICK_DIV >= 6 && t / TICK_DIV <= 8);
          else rx_in[ch] <= fr[i];
        end
      @(posedge mclk);
      rx_in[ch] <= ir ? inv : 1'b1;
    end
  endtask
  // Mid-bit sampling; unknown byte when no start bit appears
  task recv(input integer ch, output [7:0] b);
    integer i, n;
    begin
      b = 8'hxx;
      n = 0;
      while (tx_out[ch] !== 1'b0 && n < 2000) begin
        @(posedge mclk);
        n = n + 1;
      end
      if (n < 2000) begin
        repeat (BIT_CYC / 2 + BIT_CYC) @(posedge mclk);
        for (i = 0; i < 8; i = i + 1) begin
          b[i] = tx_out[ch];
          repeat (BIT_CYC) @(posedge mclk);
        end
      end
    end
  endtask
endmodule

// file: tb_top.sv
`timescale 1ns/10ps
`include "quad_uart_pins_consts.vh"
module tb_top;
  localparam TDIV = 1;
  reg mclk = 1'b0;
  reg reset, avs_read, avs_write;
  reg [6:0] avs_address;
  reg [31:0] avs_writedata, rd;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, irq;
  wire [3:0] tx_out, infrared_tx_out, rts_n, dtr_n, rx_in;
  reg [3:0] cts_n, dsr_n, ri_n, cd_n, ir_q, tx_q;
  reg [7:0] b, v;
  reg [7:0] exp_q[$]; // Behavioural model: bytes in flight, oldest first
  integer n_fail = 0, n_checks = 0, c, i, k, s;
  integer ir_rise[0:3], tx_rise[0:3];
  always #25 mclk = ~mclk;
  quad_uart_serial_modem_pins #(.NUM_CH(4), .TICK_DIV(TDIV)) uut (.mclk(mclk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_out(tx_out), .infrared_tx_out(infrared_tx_out), .rts_n(rts_n), .dtr_n(dtr_n), .rx_in(rx_in),
    .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .irq(irq));
  remote_serial_peer #(.TICK_DIV(TDIV)) peer (.mclk(mclk), .tx_out(tx_out), .rx_in(rx_in));
  // Pulse counts per channel for the pulse-code model
  always @(posedge mclk) begin
    ir_q <= infrared_tx_out;
    tx_q <= tx_out;
    for (k = 0; k < 4; k = k + 1) begin
      if (infrared_tx_out[k] && !ir_q[k]) ir_rise[k] = ir_rise[k] + 1;
      if (tx_out[k] && !tx_q[k]) tx_rise[k] = tx_rise[k] + 1;
    end
  end
  task wrap_up;
    begin
      if (n_fail == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask
  // Counts are bench integers, so a plain widening is safe
  task cmp_n(input integer got, input integer exp);
    cmp(got, exp);
  endtask
  // One Avalon transfer; held until waitrequest is seen low
  task acc(input bit wr, input [1:0] ch, input [2:0] idx, input [7:0] wd);
    integer n;
    begin
      n = 0;
      @(posedge mclk);
      avs_address <= {ch, idx, 2'b00};
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {24'h0, wd};
      do begin
        @(posedge mclk);
        n = n + 1;
      end while (avs_waitrequest !== 1'b0);
      // Answer comes one cycle after the request is seen
      cmp_n(n, 2);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  // Send a random byte; a zero bit is one pulse, so pulses = 9 - ones
  task tx_byte(input [1:0] ch, input bit ir);
    integer zi, zt;
    begin
      b = $urandom;
      zi = ir_rise[ch];
      zt = tx_rise[ch];
      acc(1, ch, `REG_DATA, b);
      if (ir) repeat (200) @(posedge mclk);
      else begin
        exp_q.push_back(b);
        peer.recv(ch, v);
        cmp(v, exp_q.pop_front());
        repeat (40) @(posedge mclk);
      end
      cmp_n(ir_rise[ch] - zi, 9 - $countones(b));
      if (ir) cmp_n(tx_rise[ch] - zt, 9 - $countones(b));
      cmp(tx_out[ch], !ir);
    end
  endtask
  // Receive a random byte; the sticky bit drives irq only when enabled
  task rx_byte(input [1:0] ch, input bit ir, input bit inv, input bit en);
    begin
      b = $urandom;
      acc(1, ch, `REG_INT_CLEAR, 8'hff);
      acc(1, ch, `REG_INT_ENABLE, {7'h0, en});
      exp_q.push_back(b);
      peer.send(ch, b, ir, inv);
      repeat (20) @(posedge mclk);
      cmp(irq, en);
      cmp(rts_n[ch], 1'b1);
      acc(0, ch, `REG_INT_STATUS, 8'h00);
      cmp(rd[0], 1'b1);
      acc(0, ch, `REG_DATA, 8'h00);
      cmp(rd, exp_q.pop_front());
      acc(1, ch, `REG_INT_CLEAR, 8'h01);
      repeat (2) @(posedge mclk);
      cmp(irq, 1'b0);
    end
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail = n_fail + 1;
    wrap_up;
  end
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 7'h00;
    avs_writedata = 32'h0;
    {cts_n, dsr_n, ri_n, cd_n} = 16'h0fff;
    for (c = 0; c < 4; c = c + 1) begin
      ir_rise[c] = 0;
      tx_rise[c] = 0;
    end
    s = $urandom(34);
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    cmp(tx_out, 4'hf);
    cmp(infrared_tx_out, 4'h0);
    cmp({rts_n, dtr_n}, 8'hff);
    // Control registers come up cleared; index 7 reads zero
    for (c = 0; c < 4; c = c + 1)
      for (i = 1; i < 8; i = i + 1)
        if (i < 5 || i == 7) begin
          acc(0, c, i, 8'h00);
          cmp(rd, 32'h0);
        end
    // Control bits reach handshake outputs and select the line mode
    for (c = 0; c < 4; c = c + 1) begin
      v = $urandom & 8'h43;
      acc(1, c, `REG_MODEM_CTRL, v);
      repeat (3) @(posedge mclk);
      cmp(dtr_n[c], !v[0]);
      cmp(rts_n[c], !v[1]);
      cmp(tx_out[c], !v[6]);
      acc(0, c, `REG_MODEM_CTRL, 8'h00);
      cmp(rd & 32'h43, v);
      acc(1, c, `REG_MODEM_CTRL, 8'h00);
    end
    // Modem inputs read back as active-high status
    repeat (4) begin
      {cd_n, ri_n, dsr_n, cts_n} <= 16'($urandom);
      repeat (8) @(posedge mclk);
      for (c = 0; c < 4; c = c + 1) begin
        acc(0, c, `REG_MODEM_STAT, 8'h00);
        cmp(rd[3:0] ^ 4'hf, {cd_n[c], ri_n[c], dsr_n[c], cts_n[c]});
      end
    end
    cts_n <= 4'h0;
    for (c = 0; c < 4; c = c + 1) tx_byte(c, 1'b0);
    // Pulse-coded mode; the line is parked low before decoding starts
    c = $urandom % 4;
    acc(1, c, `REG_MODEM_CTRL, 8'h40);
    peer.rx_in[c] <= 1'b0;
    tx_byte(c, 1'b1);
    rx_byte(c, 1'b1, 1'b0, 1'b1);
    peer.rx_in[c] <= 1'b1;
    acc(1, c, `REG_FEATURE_CTRL, 8'h04);
    repeat (400) @(posedge mclk);
    rx_byte(c, 1'b1, 1'b1, 1'b0);
    acc(1, c, `REG_FEATURE_CTRL, 8'h00);
    acc(1, c, `REG_MODEM_CTRL, 8'h00);
    repeat (400) @(posedge mclk);
    rx_byte(c, 1'b0, 1'b0, 1'b1);
    // Request asserted by software first, then automatic release
    acc(1, c, `REG_MODEM_CTRL, 8'h02);
    acc(1, c, `REG_FEATURE_CTRL, 8'h01);
    acc(1, c, `REG_ENH_FEATURE, 8'h40);
    cmp(rts_n[c], 1'b0);
    rx_byte(c, 1'b0, 1'b0, 1'b0);
    repeat (16 * TDIV + 8) @(posedge mclk);
    cmp(rts_n[c], 1'b0);
    acc(1, c, `REG_ENH_FEATURE, 8'h80);
    acc(1, c, `REG_MODEM_CTRL, 8'h00);
    // Clear-to-send gates the next character
    cts_n[c] <= 1'b1;
    // Let the pin filter settle before the byte is queued
    repeat (8) @(posedge mclk);
    fork
      tx_byte(c, 1'b0);
      begin
        repeat (80) @(posedge mclk);
        cmp(tx_out[c], 1'b1);
        cts_n[c] <= 1'b0;
      end
    join
    wrap_up;
  end
endmodule
